// [gwd_top.sv]
// Contract
// - 8-bit up counter raises internal reset when it overflows unattended.
// - counter clock is system clock /64 to /8192 or internal oscillator.
// - oscillator-clocked watchdog keeps guarding in every chip mode.
// - overflow period settable from 1 to 256 counter clocks.
// - counter write enable changes only when bit 7 written as 0.
// - counter accepts writes only while counter write enable is 1.
// - register write enable changes only when bit 5 written as 0.
// - run and flag bits writable only while register write enable is 1.
// - run bit changes only when bit 3 written as 0.
// - counter counts while run is 1, holds while run is 0.
// - run set or cleared by guarded write; cleared by reset pin.
// - flag bit changes only when bit 1 written as 0.
// - flag bit set on every overflow; an overflow while internal reset is held does not restart it.
// - flag cleared by reset pin or guarded write of 0.
// - inhibit positions 7, 5, 3, 1 always read as 1.
// - select codes 1000-1111 give /64../8192, MSB 0 gives oscillator.
// - internal reset held for 256 oscillator cycles after overflow.
// - counter resets to 00 and resumes counting from a written value.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module gwd_top
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // internal oscillator level
  input  wire logic              osc_in,
  // chip reset request
  output logic                   wdt_reset_out
);

  ////////////////////////////////////////////////////////////////////////////
  gwd_pkg::gwd_state_t st_r;
  gwd_pkg::gwd_state_t st_nxt;
  logic                access;
  logic                wr;
  logic                hit_ctrl;
  logic                hit_count;
  logic                hit_clksel;
  logic                wr_ctrl;
  logic                wr_count;
  logic                wr_clksel;
  logic                overflow;
  logic [7:0]          ctrl_read;
  logic [7:0]          wd;

  gwd_tick_if tk ();

  gwd_prescaler u_pre
  (
    .clk    (clk),
    .reset  (reset),
    .osc_in (osc_in),
    .tk     (tk)
  );

  assign tk.clock_select = st_r.clksel;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode, zero wait states
  assign access     = psel & penable;
  assign wr         = access & pwrite;
  assign hit_ctrl   = paddr == ADDR_W'(gwd_pkg::OFF_CTRL);
  assign hit_count  = paddr == ADDR_W'(gwd_pkg::OFF_COUNT);
  assign hit_clksel = paddr == ADDR_W'(gwd_pkg::OFF_CLKSEL);
  assign wr_ctrl    = wr & hit_ctrl;
  assign wr_count   = wr & hit_count;
  assign wr_clksel  = wr & hit_clksel;
  assign wd         = pwdata[7:0];
  assign pready     = 1'b1;
  assign pslverr    = access & ~(hit_ctrl | hit_count | hit_clksel);

  always_comb
  begin
    ctrl_read                        = gwd_pkg::INHIBIT_READ_MASK;
    ctrl_read[gwd_pkg::BIT_CWE]      = st_r.cwe;
    ctrl_read[gwd_pkg::BIT_RWE]      = st_r.rwe;
    ctrl_read[gwd_pkg::BIT_RUN]      = st_r.run;
    ctrl_read[gwd_pkg::BIT_FLAG]     = st_r.flag;
  end

  always_comb
  begin
    prdata = 32'h0000_0000;
    if (psel & ~pwrite)
    begin
      if (hit_ctrl)
      begin
        prdata[7:0] = ctrl_read;
      end
      else if (hit_count)
      begin
        prdata[7:0] = st_r.count;
      end
      else if (hit_clksel)
      begin
        prdata[7:0] = {gwd_pkg::CLKSEL_UPPER, st_r.clksel};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overflow from ff on a tick
  // oscillator tick runs regardless of chip mode
  assign overflow = st_r.run & tk.count_tick & (st_r.count == gwd_pkg::COUNT_MAX);

  always_comb
  begin
    st_nxt = st_r;

    // counter enable guarded by bit 7
    if (wr_ctrl && !wd[gwd_pkg::BIT_CWE_INH])
    begin
      st_nxt.cwe = wd[gwd_pkg::BIT_CWE];
    end
    // register enable guarded by bit 5
    if (wr_ctrl && !wd[gwd_pkg::BIT_RWE_INH])
    begin
      st_nxt.rwe = wd[gwd_pkg::BIT_RWE];
    end
    if (wr_ctrl && st_r.rwe && !wd[gwd_pkg::BIT_RUN_INH])
    begin
      st_nxt.run = wd[gwd_pkg::BIT_RUN];
    end
    if (wr_ctrl && st_r.rwe && !wd[gwd_pkg::BIT_FLAG_INH])
    begin
      st_nxt.flag = wd[gwd_pkg::BIT_FLAG];
    end
    // overflow sets flag, wins over clear
    if (overflow)
    begin
      st_nxt.flag = 1'b1;
    end

    // write loads counter, wins over a tick
    if (wr_count && st_r.cwe)
    begin
      st_nxt.count = wd;
    end
    else if (st_r.run && tk.count_tick)
    begin
      st_nxt.count = st_r.count + 8'h01;
    end

    if (wr_clksel)
    begin
      st_nxt.clksel = wd[3:0];
    end

    // hold internal reset for 256 oscillator cycles
    case (st_r.phase)
      gwd_pkg::GWD_IDLE:
      begin
        if (overflow)
        begin
          st_nxt.phase   = gwd_pkg::GWD_HOLD;
          st_nxt.rst_cnt = gwd_pkg::RST_CNT_RESET;
        end
      end
      gwd_pkg::GWD_HOLD:
      begin
        if (tk.osc_tick)
        begin
          if (st_r.rst_cnt == gwd_pkg::RST_HOLD_LAST)
          begin
            st_nxt.phase = gwd_pkg::GWD_IDLE;
          end
          else
          begin
            st_nxt.rst_cnt = st_r.rst_cnt + 9'h001;
          end
        end
      end
      default:
      begin
        st_nxt.phase = gwd_pkg::GWD_IDLE;
      end
    endcase
  end

  // reset pin clears run and flag
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_r.cwe     <= gwd_pkg::CWE_RESET;
      st_r.rwe     <= gwd_pkg::RWE_RESET;
      st_r.run     <= gwd_pkg::RUN_RESET;
      st_r.flag    <= gwd_pkg::FLAG_RESET;
      st_r.count   <= gwd_pkg::COUNT_RESET;
      st_r.clksel  <= gwd_pkg::CLKSEL_RESET;
      st_r.phase   <= gwd_pkg::GWD_IDLE;
      st_r.rst_cnt <= gwd_pkg::RST_CNT_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign wdt_reset_out = st_r.phase == gwd_pkg::GWD_HOLD;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  cnt_hold_a: assert property (
    (!st_r.run && !wr_count) |=> $stable(st_r.count))
    else $error("counter moved while stopped");

  cnt_step_a: assert property (
    (st_r.run && tk.count_tick && !wr_count && st_r.count != 8'hff)
      |=> st_r.count == $past(st_r.count) + 8'h01)
    else $error("counter did not step on tick");

  ovf_flag_a: assert property (
    overflow |=> st_r.flag)
    else $error("overflow without flag");

  // a load in the same cycle wins, and a running pulse is not restarted
  ovf_reset_a: assert property (
    (overflow && !(wr_count && st_r.cwe) && st_r.phase == gwd_pkg::GWD_IDLE)
      |=> (wdt_reset_out && st_r.count == 8'h00))
    else $error("overflow without internal reset or wrap");

  flag_keep_a: assert property (
    (!overflow && !wr_ctrl) |=> $stable(st_r.flag))
    else $error("flag changed without write or overflow");

  run_keep_a: assert property (
    !wr_ctrl |=> $stable(st_r.run))
    else $error("run changed without write");

  cnt_write_a: assert property (
    (wr_count && st_r.cwe) |=> st_r.count == $past(wd))
    else $error("counter did not take written value");

  cwe_guard_a: assert property (
    (wr_ctrl && wd[7]) |=> $stable(st_r.cwe))
    else $error("counter enable changed under inhibit");

  rwe_guard_a: assert property (
    (wr_ctrl && wd[5]) |=> $stable(st_r.rwe))
    else $error("register enable changed under inhibit");

  run_guard_a: assert property (
    (wr_ctrl && (!st_r.rwe || wd[3])) |=> $stable(st_r.run))
    else $error("run changed without permission");

  flag_guard_a: assert property (
    (wr_ctrl && !overflow && (!st_r.rwe || wd[1])) |=> $stable(st_r.flag))
    else $error("flag changed without permission");

  cnt_load_a: assert property (
    (wr_count && !st_r.cwe && !st_r.run) |=> $stable(st_r.count))
    else $error("counter written while locked");

  inh_read_a: assert property (
    (psel && !pwrite && hit_ctrl) |-> ((prdata[7:0] & 8'haa) == 8'haa))
    else $error("inhibit bits not read as one");

  hold_len_a: assert property (
    (wdt_reset_out && !(tk.osc_tick && st_r.rst_cnt == 9'h0ff)) |=> wdt_reset_out)
    else $error("internal reset ended early");

endmodule

// [gwd_pkg.sv]
package gwd_pkg;

  // register byte addresses
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_COUNT  = 8'h04;
  localparam logic [7:0] OFF_CLKSEL = 8'h08;

  // control/status bit positions
  localparam int BIT_CWE_INH  = 7;
  localparam int BIT_CWE      = 6;
  localparam int BIT_RWE_INH  = 5;
  localparam int BIT_RWE      = 4;
  localparam int BIT_RUN_INH  = 3;
  localparam int BIT_RUN      = 2;
  localparam int BIT_FLAG_INH = 1;
  localparam int BIT_FLAG     = 0;

  // inhibit positions always read as one
  localparam logic [7:0] INHIBIT_READ_MASK = 8'haa;

  // reset values, counter top value and clksel read-back upper bits
  localparam logic       CWE_RESET     = 1'b0;
  localparam logic       RWE_RESET     = 1'b0;
  localparam logic       RUN_RESET     = 1'b0;
  localparam logic       FLAG_RESET    = 1'b0;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] COUNT_MAX     = 8'hff;
  localparam logic [3:0] CLKSEL_RESET  = 4'hf;
  localparam logic [3:0] CLKSEL_UPPER  = 4'hf;

  // prescaler: smallest division is 2**6 = 64, largest 2**13 = 8192
  localparam int          DIV_W        = 13;
  localparam logic [12:0] DIV_MIN_MASK = 13'h003f;
  localparam logic [12:0] DIV_RESET    = 13'h0000;

  // internal reset pulse length in oscillator cycles
  localparam int         RST_HOLD_OSC = 256;
  localparam logic [8:0] RST_HOLD_LAST = 9'(RST_HOLD_OSC - 1);
  localparam logic [8:0] RST_CNT_RESET = 9'h000;

  typedef enum logic [0:0]
  {
    GWD_IDLE = 1'b0,
    GWD_HOLD = 1'b1
  } gwd_phase_t;

  typedef struct packed
  {
    logic        cwe;
    logic        rwe;
    logic        run;
    logic        flag;
    logic [7:0]  count;
    logic [3:0]  clksel;
    gwd_phase_t  phase;
    logic [8:0]  rst_cnt;
  } gwd_state_t;

  typedef struct packed
  {
    logic [DIV_W-1:0] div;
    logic             osc_prev;
  } gwd_pre_state_t;

endpackage

// [gwd_tick_if.sv]
`timescale 1ns/100ps
interface gwd_tick_if;
  logic [3:0] clock_select;
  logic       count_tick;
  logic       osc_tick;

  modport core
  (
    output clock_select,
    input  count_tick,
    input  osc_tick
  );

  modport pre
  (
    input  clock_select,
    output count_tick,
    output osc_tick
  );
endinterface

// [gwd_prescaler.sv]
`timescale 1ns/100ps
module gwd_prescaler
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // internal oscillator, sampled level
  input  wire logic osc_in,
  // ticks to the core
  gwd_tick_if.pre   tk
);

  gwd_pkg::gwd_pre_state_t st_r;
  gwd_pkg::gwd_pre_state_t st_nxt;
  logic [gwd_pkg::DIV_W-1:0] mask;
  logic                      div_tick;

  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.div      = st_r.div + 13'h0001;
    st_nxt.osc_prev = osc_in;
    mask     = 13'((14'h0040 << tk.clock_select[2:0]) - 14'h0001);
    div_tick = (st_r.div & mask) == mask;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_r.div      <= gwd_pkg::DIV_RESET;
      st_r.osc_prev <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign tk.osc_tick   = osc_in & ~st_r.osc_prev;
  assign tk.count_tick = tk.clock_select[3] ? div_tick : tk.osc_tick;

  slow_div_a: assert property (@(posedge clk) disable iff (reset)
    (tk.clock_select == 4'hf && tk.count_tick) |-> (st_r.div == 13'h1fff))
    else $error("divide-by-8192 tick at wrong divider value");

endmodule

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  logic        clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        osc_in;
  logic        wdt_reset_out;
  logic [31:0] rd;
  logic        err;
  int          n_fail;
  int          checks_done;

  gwd_top #(.ADDR_W(8)) DUT
  (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_in(osc_in), .wdt_reset_out(wdt_reset_out)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(what, rd, {24'h000000, exp});
  endtask

  // let this edge's updates land before looking
  task automatic ochk(input logic exp);
    #1;
    chk("reset_out", {31'h0, wdt_reset_out}, {31'h0, exp});
  endtask

  task automatic osc(input int n);
    repeat (n)
    begin
      @(posedge clk);
      osc_in <= 1'b1;
      repeat (2) @(posedge clk);
      osc_in <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #600000;
    n_fail++;
    summarize();
  end

  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    osc_in = 1'b0;
    n_fail = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rchk("ctrl", gwd_pkg::OFF_CTRL, 8'haa);
    rchk("count", gwd_pkg::OFF_COUNT, 8'h00);
    rchk("clksel", gwd_pkg::OFF_CLKSEL, 8'hff);
    apb(1'b0, 8'h0c, 8'h00);
    chk("unmapped err", {31'h0, err}, 32'h1);
    $display("test reset values done");
    // guarded writes
    wr(gwd_pkg::OFF_CTRL, 8'h34);
    rchk("ctrl", gwd_pkg::OFF_CTRL, 8'haa);
    wr(gwd_pkg::OFF_CTRL, 8'h14);
    rchk("ctrl", gwd_pkg::OFF_CTRL, 8'hba);
    wr(gwd_pkg::OFF_CTRL, 8'h1c);
    rchk("ctrl", gwd_pkg::OFF_CTRL, 8'hba);
    wr(gwd_pkg::OFF_COUNT, 8'h55);
    rchk("count", gwd_pkg::OFF_COUNT, 8'h00);
    wr(gwd_pkg::OFF_CTRL, 8'hd0);
    rchk("ctrl", gwd_pkg::OFF_CTRL, 8'hba);
    $display("test guards done");
    // oscillator counting and overflow
    wr(gwd_pkg::OFF_CLKSEL, 8'h00);
    rchk("clksel", gwd_pkg::OFF_CLKSEL, 8'hf0);
    wr(gwd_pkg::OFF_CTRL, 8'h54);
    rchk("ctrl", gwd_pkg::OFF_CTRL, 8'hfe);
    wr(gwd_pkg::OFF_COUNT, 8'hfd);
    osc(1);
    rchk("count", gwd_pkg::OFF_COUNT, 8'hfe);
    wr(gwd_pkg::OFF_CTRL, 8'h50);
    osc(2);
    rchk("count", gwd_pkg::OFF_COUNT, 8'hfe);
    wr(gwd_pkg::OFF_CTRL, 8'h54);
    osc(1);
    rchk("count", gwd_pkg::OFF_COUNT, 8'hff);
    ochk(1'b0);
    osc(1);
    ochk(1'b1);
    rchk("ctrl", gwd_pkg::OFF_CTRL, 8'hff);
    rchk("count", gwd_pkg::OFF_COUNT, 8'h00);
    wr(gwd_pkg::OFF_CTRL, 8'h52);
    rchk("ctrl", gwd_pkg::OFF_CTRL, 8'hfb);
    osc(255);
    ochk(1'b1);
    osc(1);
    ochk(1'b0);
    wr(gwd_pkg::OFF_CTRL, 8'h50);
    rchk("ctrl", gwd_pkg::OFF_CTRL, 8'hfa);
    $display("test overflow done");
    // shortest period, then reset pin in mid-run
    wr(gwd_pkg::OFF_COUNT, 8'hff);
    wr(gwd_pkg::OFF_CTRL, 8'h54);
    osc(1);
    ochk(1'b1);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rchk("ctrl", gwd_pkg::OFF_CTRL, 8'haa);
    rchk("count", gwd_pkg::OFF_COUNT, 8'h00);
    $display("test reset pin done");
    // every prescaler code: one to three ticks within two periods
    wr(gwd_pkg::OFF_CTRL, 8'h50);
    wr(gwd_pkg::OFF_CTRL, 8'h54);
    for (int k = 0; k < 8; k++)
    begin
      wr(gwd_pkg::OFF_CLKSEL, 8'h08 + 8'(k));
      wr(gwd_pkg::OFF_COUNT, 8'h00);
      repeat (2 * (64 << k)) @(posedge clk);
      apb(1'b0, gwd_pkg::OFF_COUNT, 8'h00);
      chk("div ticks", {31'h0, rd[7:0] >= 8'h01 && rd[7:0] <= 8'h03}, 32'h1);
    end
    $display("test prescaler done");
    summarize();
  end
endmodule
